// ===== motion_sync_consts.svh
// Purpose: Register offsets, field positions, reset values for motion command sync control
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Included by the design file, the checker file and the bench
`ifndef MOTION_SYNC_CONSTS_SVH
`define MOTION_SYNC_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL        12'h000
`define OFF_CMD         12'h004
`define OFF_GO          12'h008
`define OFF_BUF_STAT    12'h00c
`define OFF_ACTIVE      12'h010
`define OFF_AXIS_STAT   12'h014
`define OFF_IRQ_STAT    12'h018
`define OFF_IRQ_EN      12'h01c
`define OFF_IRQ_CLR     12'h020
`define OFF_VERSION     12'h024

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_START_TYPE_LSB  0
`define CTRL_WAIT_MASK_LSB   2
`define CTRL_HALT_ON_STOP    6
`define CTRL_FAULT_STOP_OUT  7
`define CTRL_HALT_STYLE      8
`define CTRL_CONTINUOUS      9

// ----------------------------------------
// Go register command bits
// ----------------------------------------
`define GO_START    0
`define GO_STOP     1
`define GO_DONE     2

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define IRQ_STARTED  0
`define IRQ_STOPPED  1
`define IRQ_FAULT    2
`define IRQ_OVERWRITE 3

// ----------------------------------------
// Version and reset values
// ----------------------------------------
`define VER_QUEUE_BIT   12
`define CTRL_RESET      32'h0000_0000

`endif

// ===== motion_sync_pkg.sv
// Purpose: Types for motion command sync control
// Assumes: Nothing beyond the constants header
// Notes:   States are one-hot
package motion_sync_pkg;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_WAIT  = 4'b0010,
      ST_RUN   = 4'b0100,
      ST_HALT  = 4'b1000
   } run_state_t;

   typedef enum logic [1:0] {
      START_NOW  = 2'h0,
      START_GO   = 2'h1,
      START_RSVD = 2'h2,
      START_AXES = 2'h3
   } start_type_t;

endpackage

// ===== motion_sync_ctrl.sv
// Purpose: Motion command queue, start/stop coordination and fault stop output
// Assumes: srst synchronous active high; inputs synchronous to clock
// Notes:   Motion profile generation itself lies outside; run_cmd carries the active command
`timescale 1ns/10ps
`include "motion_sync_consts.svh"

// Summary of operation
// - Software can read whether the command pre-register is empty.
// - Writing while the queue is full replaces the second pre-register command.
// - With version bit 12 clear, status reads 1 only while pre-register two is busy.
// - With version bit 12 set, status reads 0 empty, 1 active, 2 reg one, 3 reg two.
// - Coordinated start and stop act on all selected axes in the same cycle.
// - A global start launches the prepared relative trapezoidal move.
// - Start type: 0 now, 1 wait for go, 2 reserved, 3 wait on axes.
// - Wait mask bit per axis 0 to 3; start out of ST_WAIT held until all masked axes stop.
// - With halt-on-stop enabled, the axis stops while the coordinated stop line is high.
// - With fault stop enabled, an abnormal stop drives the coordinated stop line.
// - Halt style 0 stops at once, 1 decelerates; used by go-stop and stop line.
module motion_sync_ctrl #(
   parameter int       CMD_W      = 32,
   parameter bit       QUEUE_VER  = 1'b1,
   parameter logic [11:0] VER_CODE = 12'h001   // Arbitrary value
) (
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              coordinated_go_line,
   input  wire logic              coordinated_stop_in,
   input  wire logic [3:0]        axis_stopped,
   input  wire logic              drive_alarm_input,
   input  wire logic              end_limit_input,
   input  wire logic              motion_done,
   output logic                   coordinated_stop_out,
   output logic                   run_start,
   output logic                   run_active,
   output logic                   halt_now,
   output logic                   halt_slow,
   output logic      [CMD_W-1:0]  run_cmd,
   output logic                   continuous_mode,
   output logic                   irq
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [31:0]             ctrl_reg;
   logic [3:0]              irq_stat_reg;
   logic [3:0]              irq_en_reg;
   logic [CMD_W-1:0]        pre1_reg;
   logic [CMD_W-1:0]        pre2_reg;
   logic                    act_busy_reg;
   logic                    pre1_busy_reg;
   logic                    pre2_busy_reg;
   motion_sync_pkg::run_state_t state_reg;
   motion_sync_pkg::run_state_t state_next;

   logic                    wr_en;
   logic                    cmd_wr;
   logic                    go_start;
   logic                    go_stop;
   logic                    go_done;
   logic                    fault;
   logic                    stop_req;
   logic                    launch;
   logic                    finish;
   logic                    start_ok;
   logic [3:0]              wait_mask;
   logic [1:0]              buf_stat;
   logic [3:0]              irq_set;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   // Zero wait state: pready registered so the answer lands one cycle into access.
   assign wr_en    = psel && penable && pwrite && pready;
   assign cmd_wr   = wr_en && hit(paddr, `OFF_CMD);
   assign go_start = wr_en && hit(paddr, `OFF_GO) && pwdata[`GO_START];
   assign go_stop  = wr_en && hit(paddr, `OFF_GO) && pwdata[`GO_STOP];
   assign go_done  = motion_done || (wr_en && hit(paddr, `OFF_GO) && pwdata[`GO_DONE]);
   assign wait_mask = ctrl_reg[`CTRL_WAIT_MASK_LSB +: 4];

   always_ff @(posedge clock) begin
      if (srst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl_reg   <= `CTRL_RESET;
         irq_en_reg <= 4'h0;
      end else if (wr_en) begin
         if (hit(paddr, `OFF_CTRL)) begin
            ctrl_reg <= pwdata & 32'h0000_03ff;
         end
         if (hit(paddr, `OFF_IRQ_EN)) begin
            irq_en_reg <= pwdata[3:0];
         end
      end
   end

   // ----------------------------------------
   // Start and stop conditions
   // ----------------------------------------
   always_comb begin
      unique case (motion_sync_pkg::start_type_t'(ctrl_reg[`CTRL_START_TYPE_LSB +: 2]))
         motion_sync_pkg::START_NOW:  start_ok = 1'b1;
         motion_sync_pkg::START_GO:   start_ok = go_start || coordinated_go_line;
         motion_sync_pkg::START_RSVD: start_ok = 1'b0;
         motion_sync_pkg::START_AXES: start_ok = ((axis_stopped & wait_mask) == wait_mask);
      endcase
   end

   assign fault    = drive_alarm_input || end_limit_input;
   assign stop_req = go_stop || fault ||
                     (ctrl_reg[`CTRL_HALT_ON_STOP] && coordinated_stop_in);

   // ----------------------------------------
   // Run state machine
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      launch     = 1'b0;
      finish     = 1'b0;
      unique case (state_reg)
         motion_sync_pkg::ST_IDLE: begin
            if (act_busy_reg) begin
               state_next = motion_sync_pkg::ST_WAIT;
            end
         end
         motion_sync_pkg::ST_WAIT: begin
            if (stop_req) begin
               finish     = 1'b1;
               state_next = motion_sync_pkg::ST_IDLE;
            end else if (start_ok) begin
               launch     = 1'b1;
               state_next = motion_sync_pkg::ST_RUN;
            end
         end
         motion_sync_pkg::ST_RUN: begin
            if (stop_req) begin
               state_next = motion_sync_pkg::ST_HALT;
            end else if (go_done) begin
               finish     = 1'b1;
               state_next = pre1_busy_reg ? motion_sync_pkg::ST_RUN
                                          : motion_sync_pkg::ST_IDLE;
               launch     = pre1_busy_reg;
            end
         end
         motion_sync_pkg::ST_HALT: begin
            if (go_done) begin
               finish     = 1'b1;
               state_next = motion_sync_pkg::ST_IDLE;
            end
         end
         default: state_next = motion_sync_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= motion_sync_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // Command queue: active, pre-register one, pre-register two
   // ----------------------------------------
   // A finish shifts the queue down in the same cycle, so chained moves leave no gap.
   always_ff @(posedge clock) begin
      if (srst) begin
         act_busy_reg  <= 1'b0;
         pre1_busy_reg <= 1'b0;
         pre2_busy_reg <= 1'b0;
         run_cmd       <= '0;
         pre1_reg      <= '0;
         pre2_reg      <= '0;
      end else begin
         if (finish) begin
            act_busy_reg  <= pre1_busy_reg || cmd_wr;
            run_cmd       <= pre1_busy_reg ? pre1_reg : pwdata[CMD_W-1:0];
            pre1_busy_reg <= pre2_busy_reg || (pre1_busy_reg && cmd_wr);
            pre1_reg      <= pre2_busy_reg ? pre2_reg : pwdata[CMD_W-1:0];
            pre2_busy_reg <= pre2_busy_reg && cmd_wr;
            if (cmd_wr) begin
               pre2_reg <= pwdata[CMD_W-1:0];
            end
         end else if (cmd_wr) begin
            if (!act_busy_reg) begin
               act_busy_reg <= 1'b1;
               run_cmd      <= pwdata[CMD_W-1:0];
            end else if (!pre1_busy_reg) begin
               pre1_busy_reg <= 1'b1;
               pre1_reg      <= pwdata[CMD_W-1:0];
            end else begin
               pre2_busy_reg <= 1'b1;
               pre2_reg      <= pwdata[CMD_W-1:0];
            end
         end
      end
   end

   // ----------------------------------------
   // Buffer status
   // ----------------------------------------
   always_comb begin
      if (!QUEUE_VER) begin
         buf_stat = {1'b0, pre2_busy_reg};
      end else if (pre2_busy_reg) begin
         buf_stat = 2'h3;
      end else if (pre1_busy_reg) begin
         buf_stat = 2'h2;
      end else if (act_busy_reg) begin
         buf_stat = 2'h1;
      end else begin
         buf_stat = 2'h0;
      end
   end

   // ----------------------------------------
   // Outputs to the axes and the shared lines
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         run_start            <= 1'b0;
         run_active           <= 1'b0;
         halt_now             <= 1'b0;
         halt_slow            <= 1'b0;
         coordinated_stop_out <= 1'b0;
         continuous_mode      <= 1'b0;
      end else begin
         run_start  <= launch;
         run_active <= (state_next == motion_sync_pkg::ST_RUN);
         halt_now   <= stop_req && !ctrl_reg[`CTRL_HALT_STYLE];
         halt_slow  <= stop_req && ctrl_reg[`CTRL_HALT_STYLE];
         coordinated_stop_out <= go_stop ||
                                 (ctrl_reg[`CTRL_FAULT_STOP_OUT] && fault);
         continuous_mode <= ctrl_reg[`CTRL_CONTINUOUS];
      end
   end

   // ----------------------------------------
   // Interrupts: set wins over clear
   // ----------------------------------------
   assign irq_set[`IRQ_STARTED]   = launch;
   assign irq_set[`IRQ_STOPPED]   = finish;
   assign irq_set[`IRQ_FAULT]     = fault;
   assign irq_set[`IRQ_OVERWRITE] = cmd_wr && pre2_busy_reg && !finish;

   always_ff @(posedge clock) begin
      if (srst) begin
         irq_stat_reg <= 4'h0;
      end else if (wr_en && hit(paddr, `OFF_IRQ_CLR)) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | irq_set;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_set;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_stat_reg | irq_set) & irq_en_reg);
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (hit(paddr, `OFF_CTRL)) prdata <= ctrl_reg;
         else if (hit(paddr, `OFF_BUF_STAT)) prdata <= {30'h0, buf_stat};
         else if (hit(paddr, `OFF_ACTIVE)) prdata <= 32'(run_cmd);
         else if (hit(paddr, `OFF_AXIS_STAT)) prdata <= {24'h0, state_reg, axis_stopped};
         else if (hit(paddr, `OFF_IRQ_STAT)) prdata <= {28'h0, irq_stat_reg};
         else if (hit(paddr, `OFF_IRQ_EN)) prdata <= {28'h0, irq_en_reg};
         else if (hit(paddr, `OFF_VERSION)) prdata <= {19'h0, QUEUE_VER, VER_CODE};
         else if (!(hit(paddr, `OFF_CMD) || hit(paddr, `OFF_GO) ||
                    hit(paddr, `OFF_IRQ_CLR))) pslverr <= 1'b1;
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end

endmodule

// ===== motion_sync_ctrl_asserts.sv
// Purpose: Port-level checks for motion_sync_ctrl
// Assumes: Shadows of CTRL and IRQ_EN follow completed APB writes
// Notes:   Queue contents are internal, so the queue is checked by the bench
`timescale 1ns/10ps
`include "motion_sync_consts.svh"
module motion_sync_ctrl_chk (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        coordinated_stop_in,
   input wire logic [3:0]  axis_stopped,
   input wire logic        drive_alarm_input,
   input wire logic        end_limit_input,
   input wire logic        coordinated_stop_out,
   input wire logic        run_start,
   input wire logic        run_active,
   input wire logic        halt_now,
   input wire logic        halt_slow,
   input wire logic        continuous_mode,
   input wire logic        irq
);
   // ----------------------------------------
   // Shadows and checks
   // ----------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   logic [31:0] ctrl_reg;
   logic [31:0] irq_en_reg;
   logic        wr_ok;
   logic        go_stop;
   logic        cmd_wr;
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   assign go_stop = wr_ok && paddr == `OFF_GO && pwdata[`GO_STOP];
   assign cmd_wr = wr_ok && paddr == `OFF_CMD;
   always_ff @(posedge clock) begin
      if (srst) ctrl_reg <= `CTRL_RESET;
      else if (wr_ok && paddr == `OFF_CTRL) ctrl_reg <= pwdata;
   end
   always_ff @(posedge clock) begin
      if (srst) irq_en_reg <= 32'h0;
      else if (wr_ok && paddr == `OFF_IRQ_EN) irq_en_reg <= pwdata;
   end
   property p_apb_answer;
      psel && !penable |=> pready && (pslverr == ($past(paddr) > 12'h024)) ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer wrong");
   property p_fault_out;
      run_active && ctrl_reg[7] && (drive_alarm_input || end_limit_input)
         |-> ##[1:2] coordinated_stop_out;
   endproperty
   a_fault_out: assert property (p_fault_out) else $error("no stop out");
   property p_line_halt;
      run_active && ctrl_reg[6] && coordinated_stop_in |-> ##[1:2] (ctrl_reg[8] ? halt_slow : halt_now);
   endproperty
   a_line_halt: assert property (p_line_halt) else $error("line halt wrong");
   property p_go_halt;
      go_stop && run_active |-> ##[1:2] (ctrl_reg[8] ? halt_slow : halt_now);
   endproperty
   a_go_halt: assert property (p_go_halt) else $error("go halt wrong");
   property p_mask_hold;
      (ctrl_reg[1:0] == 2'h3 && (axis_stopped & ctrl_reg[5:2]) != ctrl_reg[5:2] && !run_active)[*3]
         |-> !run_start;
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("start not held");
   property p_now_start;
      cmd_wr && ctrl_reg[1:0] == 2'h0 && !run_active && !halt_now && !halt_slow |-> ##[1:5] run_start;
   endproperty
   a_now_start: assert property (p_now_start) else $error("no start");
   property p_start_runs;
      run_start |-> ##[0:1] run_active;
   endproperty
   a_start_runs: assert property (p_start_runs) else $error("start not run");
   property p_cont;
      ctrl_reg[9] == $past(ctrl_reg[9]) |-> continuous_mode == ctrl_reg[9];
   endproperty
   a_cont: assert property (p_cont) else $error("continuous flag wrong");
   property p_irq_mask;
      (irq_en_reg == 32'h0)[*2] |-> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
endmodule

bind motion_sync_ctrl motion_sync_ctrl_chk chk (.clock(clock), .srst(srst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .coordinated_stop_in(coordinated_stop_in), .axis_stopped(axis_stopped),
   .drive_alarm_input(drive_alarm_input), .end_limit_input(end_limit_input),
   .coordinated_stop_out(coordinated_stop_out), .run_start(run_start), .run_active(run_active),
   .halt_now(halt_now), .halt_slow(halt_slow), .continuous_mode(continuous_mode), .irq(irq));

// ===== motion_far_side.sv
// Purpose: Other cards on the shared lines and the profile generator
// Assumes: Runs last run_len cycles; halts shorten them
// Notes:   A slow halt still takes three cycles, as a real ramp would
`timescale 1ns/10ps
module motion_far_side (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        go_req,
   input wire logic        stop_req,
   input wire logic [7:0]  run_len,
   input wire logic        run_start,
   input wire logic        halt_now,
   input wire logic        halt_slow,
   input wire logic        coordinated_stop_out,
   output logic            coordinated_go_line,
   output logic            coordinated_stop_in,
   output logic            motion_done
);
   // ----------------------------------------
   // Shared lines and run timer
   // ----------------------------------------
   logic [7:0] cnt_reg;
   // Every card sees the same wired stop line
   assign coordinated_stop_in = stop_req | coordinated_stop_out;
   // One go line for the whole group, one to forty-eight axes
   always_ff @(posedge clock) begin
      if (srst) coordinated_go_line <= 1'b0;
      else coordinated_go_line <= go_req;
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_reg <= 8'h00;
         motion_done <= 1'b0;
      end else begin
         motion_done <= cnt_reg == 8'h01;
         if (run_start) cnt_reg <= run_len;
         else if (halt_now && cnt_reg > 8'h01) cnt_reg <= 8'h01;
         else if (halt_slow && cnt_reg > 8'h03) cnt_reg <= 8'h03;
         else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
      end
   end
endmodule

// ===== tb_top.sv
// Purpose: Self-checking bench for motion_sync_ctrl
// Assumes: One access per APB call; far side is motion_far_side
// Notes:   Short runs keep the whole test to a few hundred cycles
`timescale 1ns/10ps
`include "motion_sync_consts.svh"
module tb_top;
   // ----------------------------------------
   // Signals, tasks and sequence
   // ----------------------------------------
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [31:0] prdata0, rd0, run_cmd_w;
   logic        pready, pslverr, serr, go_line, stop_line, motion_done;
   logic        go_req = 1'b0, stop_req = 1'b0;
   logic        drive_alarm_input = 1'b0, end_limit_input = 1'b0;
   logic [3:0]  axis_stopped = 4'h0;
   logic [7:0]  run_len = 8'h0c;
   logic        coordinated_stop_out, run_start, run_active, halt_now, halt_slow;
   logic        continuous_mode, irq;
   logic [4:0]  sigs;
   logic [31:0] exp_act [3] = '{32'h101, 32'h102, 32'h104};
   int          error_cnt = 0, compares = 0;
   assign sigs = {coordinated_stop_out, halt_now, halt_slow, motion_done, run_start};
   motion_sync_ctrl uut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .coordinated_go_line(go_line), .coordinated_stop_in(stop_line),
      .axis_stopped(axis_stopped), .drive_alarm_input(drive_alarm_input),
      .end_limit_input(end_limit_input), .motion_done(motion_done),
      .coordinated_stop_out(coordinated_stop_out), .run_start(run_start),
      .run_active(run_active), .halt_now(halt_now), .halt_slow(halt_slow), .run_cmd(run_cmd_w),
      .continuous_mode(continuous_mode), .irq(irq));
   motion_far_side far (.clock(clock), .srst(srst), .go_req(go_req), .stop_req(stop_req),
      .run_len(run_len), .run_start(run_start), .halt_now(halt_now), .halt_slow(halt_slow),
      .coordinated_stop_out(coordinated_stop_out), .coordinated_go_line(go_line),
      .coordinated_stop_in(stop_line), .motion_done(motion_done));
   // Second copy with the older status encoding, fed the same bus and lines
   motion_sync_ctrl #(.QUEUE_VER(1'b0)) uut0 (.clock(clock), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata0),
      .pready(), .pslverr(), .coordinated_go_line(go_line), .coordinated_stop_in(stop_line),
      .axis_stopped(axis_stopped), .drive_alarm_input(drive_alarm_input),
      .end_limit_input(end_limit_input), .motion_done(motion_done), .coordinated_stop_out(),
      .run_start(), .run_active(), .halt_now(), .halt_slow(), .run_cmd(), .continuous_mode(),
      .irq());
   initial forever #25 clock = ~clock;
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   task automatic hang(input string nm);
      chk(nm, 32'h1, 32'h0);
      finish_test;
   endtask
   // Request held from setup until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      rd0 = prdata0;
      serr = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 20) hang("pready");
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd & m);
   endtask
   task automatic wait_sig(input int k);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (sigs[k] !== 1'b1 && n < 200);
      chk($sformatf("signal %0d", k), 32'h1, {31'h0, sigs[k]});
      if (n >= 200) finish_test;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      rchk(`OFF_CTRL, 32'hffffffff, `CTRL_RESET);
      rchk(`OFF_VERSION, 32'h1000, 32'h1000);
      chk("version q0", 32'h0, rd0 & 32'h1000);
      apb(1'b1, `OFF_BUF_STAT, 32'h3);
      rchk(`OFF_BUF_STAT, 32'hffffffff, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk("slverr", 32'h1, {31'h0, serr});
      $display("test reset done");
      apb(1'b1, `OFF_CTRL, 32'h1);
      for (int i = 1; i <= 4; i++) begin
         apb(1'b1, `OFF_CMD, 32'h100 + 32'(i));
         rchk(`OFF_BUF_STAT, 32'h3, (i > 3) ? 32'h3 : 32'(i));
         chk("buf q0", 32'(i > 2), rd0 & 32'h3);
      end
      chk("waiting", 32'h0, {31'h0, run_active});
      rchk(`OFF_IRQ_STAT, 32'h8, 32'h8);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, `OFF_IRQ_EN, 32'h8);
      repeat (2) @(posedge clock);
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1'b1, `OFF_IRQ_CLR, 32'h8);
      repeat (2) @(posedge clock);
      chk("irq off", 32'h0, {31'h0, irq});
      go_req <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         wait_sig(0);
         go_req <= 1'b0;
         rchk(`OFF_ACTIVE, 32'hffffffff, exp_act[k]);
         chk("run_cmd", exp_act[k], run_cmd_w);
         rchk(`OFF_BUF_STAT, 32'h3, 32'(3 - k));
         chk("buf q0", 32'(k == 0), rd0 & 32'h3);
      end
      wait_sig(1);
      rchk(`OFF_BUF_STAT, 32'h3, 32'h0);
      $display("test queue done");
      apb(1'b1, `OFF_CTRL, 32'h17);
      apb(1'b1, `OFF_CMD, 32'h200);
      for (int j = 0; j < 2; j++) begin
         axis_stopped <= (j > 0) ? 4'hb : 4'h4;
         repeat (6) @(posedge clock);
         chk("held", 32'h0, {31'h0, run_active});
      end
      axis_stopped <= 4'hd;
      wait_sig(0);
      wait_sig(1);
      $display("test mask done");
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `OFF_CTRL, {23'h0, m[0], 1'b0, 1'b1, 6'h0});
         apb(1'b1, `OFF_CMD, 32'h300);
         wait_sig(0);
         if (m[1]) stop_req <= 1'b1;
         else apb(1'b1, `OFF_GO, 32'h2);
         wait_sig(m[0] ? 2 : 3);
         stop_req <= 1'b0;
         wait_sig(1);
      end
      $display("test halt done");
      apb(1'b1, `OFF_CTRL, 32'h180);
      for (int j = 0; j < 2; j++) begin
         apb(1'b1, `OFF_CMD, 32'h400);
         wait_sig(0);
         {end_limit_input, drive_alarm_input} <= (j > 0) ? 2'b10 : 2'b01;
         wait_sig(4);
         {end_limit_input, drive_alarm_input} <= 2'b00;
         wait_sig(1);
      end
      $display("test fault done");
      apb(1'b1, `OFF_CTRL, 32'h1);
      apb(1'b1, `OFF_CMD, 32'h600);
      apb(1'b1, `OFF_GO, 32'h1);
      wait_sig(0);
      apb(1'b1, `OFF_GO, 32'h4);
      rchk(`OFF_BUF_STAT, 32'h3, 32'h0);
      apb(1'b1, `OFF_CTRL, 32'h2);
      apb(1'b1, `OFF_CMD, 32'h500);
      repeat (8) @(posedge clock);
      chk("reserved", 32'h0, {31'h0, run_active});
      apb(1'b1, `OFF_GO, 32'h2);
      rchk(`OFF_BUF_STAT, 32'h3, 32'h0);
      apb(1'b1, `OFF_CTRL, 32'h200);
      repeat (2) @(posedge clock);
      chk("continuous", 32'h1, {31'h0, continuous_mode});
      apb(1'b1, `OFF_CTRL, 32'h0);
      repeat (2) @(posedge clock);
      chk("continuous", 32'h0, {31'h0, continuous_mode});
      $display("test modes done");
      finish_test;
   end
endmodule
